/* File: rtl/vlvp_pkg.sv */
package vlvp_pkg;

  // clock and one-second base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned ONE_SEC_NS = 1_000_000_000;
  localparam int unsigned SEC_CYCLES = ONE_SEC_NS / CLK_PERIOD_NS;

  // phase lengths in seconds
  localparam logic [11:0] PULSE_SECS = 12'h004;
  localparam logic [11:0] BLANK_SECS = 12'h003;

  // test time code: 0..60 s by 1 s, 70..600 s by 10 s, 11..60 min by 1 min
  localparam logic [7:0] TIME_CODE_RST = 8'h0a;
  localparam logic [7:0] TIME_CODE_MIN = 8'h0a;
  localparam logic [7:0] TIME_CODE_MAX = 8'ha4;
  localparam logic [7:0] CODE_FINE_END = 8'h3c;
  localparam logic [7:0] CODE_MID_END = 8'h72;
  localparam logic [7:0] CODE_MID_BIAS = 8'h36;
  localparam logic [7:0] CODE_COARSE_BIAS = 8'h68;
  localparam logic [11:0] MID_STEP_SECS = 12'h00a;
  localparam logic [11:0] COARSE_STEP_SECS = 12'h03c;

  // register map (byte addresses)
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] CFG_OFF = 4'h0;
  localparam logic [3:0] STATUS_OFF = 4'h4;
  localparam logic [3:0] CMD_OFF = 4'h8;
  localparam logic [3:0] TIME_OFF = 4'hc;
  localparam int unsigned CFG_SCHED_LSB = 0;
  localparam int unsigned CFG_CODE_LSB = 8;
  localparam int unsigned CMD_CLEAR_BIT = 0;
  localparam int unsigned STAT_LOCK_BIT = 8;
  localparam int unsigned STAT_BUSY_BIT = 9;
  localparam int unsigned STAT_SW_BIT = 10;
  localparam int unsigned STAT_PASS_BIT = 11;
  localparam int unsigned STAT_SEC_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SCHED_NEVER = 3'h0,
    SCHED_BEFORE = 3'h1,
    SCHED_AFTER = 3'h2,
    SCHED_BOTH = 3'h3,
    SCHED_SPLIT = 3'h4
  } vlvp_sched_e;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_LP_PULSE = 8'h02,
    ST_LP_BLANK = 8'h04,
    ST_LP_TEST = 8'h08,
    ST_HP_PULSE = 8'h10,
    ST_HP_BLANK = 8'h20,
    ST_HP_TEST = 8'h40,
    ST_LOCKOUT = 8'h80
  } vlvp_state_e;

  typedef struct packed {
    vlvp_sched_e sched;
    logic [7:0] time_code;
  } vlvp_cfg_s;

  localparam vlvp_cfg_s CFG_RST = '{sched: SCHED_NEVER, time_code: TIME_CODE_RST};

  function automatic logic [11:0] vlvp_code_to_secs(input logic [7:0] code);
    logic [11:0] base;
    base = 12'h000;
    if (code <= CODE_FINE_END) begin
      return {4'h0, code};
    end else if (code <= CODE_MID_END) begin
      base = {4'h0, code - CODE_MID_BIAS};
      return base * MID_STEP_SECS;
    end else begin
      base = {4'h0, code - CODE_COARSE_BIAS};
      return base * COARSE_STEP_SECS;
    end
  endfunction

endpackage

/* File: rtl/vlvp_sync.sv */
`timescale 1ns/1ps
module vlvp_sync
  import vlvp_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("vlvp_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

/* File: rtl/vlvp_tick.sv */
`timescale 1ns/1ps
module vlvp_tick
  import vlvp_pkg::*;
#(
  parameter int unsigned CYCLES = SEC_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic restart_i,
  output logic tick_o
);

  if (CYCLES < 2) begin : g_bad_cycles
    $error("vlvp_tick: CYCLES must be at least 2");
  end

  localparam int unsigned CNT_W = $clog2(CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // restart aligns the second boundary to phase entry
  always_comb begin
    if (restart_i || cnt_reg == CNT_LAST) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick_o = (cnt_reg == CNT_LAST);

endmodule

/* File: rtl/vlvp_sequencer.sv */
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// Function
// R01: with the never schedule no proving step is ever driven and requests finish at once.
// R02: with before, proving runs on the request made after standby and safe start check, ahead of run.
// R03: with after, proving runs on the request made when run ends, ahead of safety relay dropout.
// R04: with both, the full low and high pressure test runs at both points.
// R05: with split, only the high pressure test runs at the before point and only the low one after.
// R06: all proving times derive from an exact one-second tick, well inside ten percent.
// R07: the low pressure test opens the downstream valve alone for four seconds.
// R08: each valve pulse is followed by three seconds in which the pressure switch is ignored.
// R09: a pressure switch that turns on during the low pressure test window causes lockout.
// R10: the high pressure test then opens the upstream valve alone for four seconds.
// R11: a pressure switch that turns off during the high pressure test window causes lockout.
// R12: the test time code steps by one second to 60 s, ten seconds to 600 s, one minute to 60 min.
// R13: schedule and test time can be written only in standby or lockout.
// R14: the test time resets to ten seconds, which is also its floor.
// R15: lockout drops both valves at once and holds until a software clear.
// R16: a full run is low pressure then high pressure test, reporting done only without lockout.
module vlvp_sequencer
  import vlvp_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic before_req_i,
  input wire logic after_req_i,
  input wire logic control_standby_i,
  input wire logic interspace_pressure_switch_i,
  output logic upstream_valve_drive_o,
  output logic downstream_valve_drive_o,
  output logic prove_busy_o,
  output logic prove_done_o,
  output logic lockout_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  if (SEC_CYCLES_P < 2) begin : g_bad_sec
    $error("vlvp_sequencer: SEC_CYCLES_P must be at least 2");
  end

  logic switch_sync;
  logic sec_tick;

  vlvp_sync #(
    .WIDTH(1)
  ) u_switch_sync (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(interspace_pressure_switch_i),
    .sync_o(switch_sync)
  );

  // sequencer state
  vlvp_state_e state_reg, state_next;
  logic [11:0] sec_reg, sec_next;
  logic [11:0] test_secs_reg, test_secs_next;
  logic hp_follow_reg, hp_follow_next;
  logic up_reg, up_next;
  logic down_reg, down_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic lock_reg, lock_next;
  logic pass_reg, pass_next;

  // bus state
  vlvp_cfg_s cfg_reg, cfg_next;
  logic aw_hold_reg, aw_hold_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic w_hold_reg, w_hold_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic clear_cmd;

  logic phase_restart;
  logic pulse_end;
  logic blank_end;
  logic test_end;

  // exact second base, realigned at each phase entry
  // R06: exact second base
  vlvp_tick #(
    .CYCLES(SEC_CYCLES_P)
  ) u_sec_tick (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .restart_i(phase_restart),
    .tick_o(sec_tick)
  );

  assign phase_restart = (state_next != state_reg);
  assign pulse_end = sec_tick && (sec_reg == PULSE_SECS - 12'h001);
  assign blank_end = sec_tick && (sec_reg == BLANK_SECS - 12'h001);
  assign test_end = sec_tick && (sec_reg == test_secs_reg - 12'h001);

  always_comb begin
    state_next = state_reg;
    hp_follow_next = hp_follow_reg;
    test_secs_next = test_secs_reg;
    done_next = 1'b0;
    pass_next = pass_reg;
    case (state_reg)
      ST_IDLE: begin
        if (before_req_i) begin
          test_secs_next = vlvp_code_to_secs(cfg_reg.time_code);
          case (cfg_reg.sched)
            // R02: before point, full run
            // R04: both, before point
            SCHED_BEFORE, SCHED_BOTH: begin
              state_next = ST_LP_PULSE;
              hp_follow_next = 1'b1;
            end
            // R05: split, high test only
            SCHED_SPLIT: begin
              state_next = ST_HP_PULSE;
              hp_follow_next = 1'b0;
            end
            // R01: never skips proving
            default: begin
              done_next = 1'b1;
            end
          endcase
        end else if (after_req_i) begin
          test_secs_next = vlvp_code_to_secs(cfg_reg.time_code);
          case (cfg_reg.sched)
            // R03: after point, full run
            // R04: both, after point
            SCHED_AFTER, SCHED_BOTH: begin
              state_next = ST_LP_PULSE;
              hp_follow_next = 1'b1;
            end
            // R05: split, low test only
            SCHED_SPLIT: begin
              state_next = ST_LP_PULSE;
              hp_follow_next = 1'b0;
            end
            // R01: never skips proving
            default: begin
              done_next = 1'b1;
            end
          endcase
        end
      end
      // R07: four second vent pulse
      ST_LP_PULSE: begin
        if (pulse_end) begin
          state_next = ST_LP_BLANK;
        end
      end
      // R08: switch ignored while blanking
      ST_LP_BLANK: begin
        if (blank_end) begin
          state_next = ST_LP_TEST;
        end
      end
      ST_LP_TEST: begin
        // R09: rise means upstream leak
        if (switch_sync) begin
          state_next = ST_LOCKOUT;
          pass_next = 1'b0;
        end else if (test_end) begin
          // R16: low then high
          if (hp_follow_reg) begin
            state_next = ST_HP_PULSE;
          end else begin
            state_next = ST_IDLE;
            done_next = 1'b1;
            pass_next = 1'b1;
          end
        end
      end
      // R10: four second fill pulse
      ST_HP_PULSE: begin
        if (pulse_end) begin
          state_next = ST_HP_BLANK;
        end
      end
      // R08: switch ignored while blanking
      ST_HP_BLANK: begin
        if (blank_end) begin
          state_next = ST_HP_TEST;
        end
      end
      ST_HP_TEST: begin
        // R11: fall means downstream leak
        if (!switch_sync) begin
          state_next = ST_LOCKOUT;
          pass_next = 1'b0;
        end else if (test_end) begin
          // R16: done only without lockout
          state_next = ST_IDLE;
          done_next = 1'b1;
          pass_next = 1'b1;
        end
      end
      // R15: held until software clear
      ST_LOCKOUT: begin
        if (clear_cmd) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_LOCKOUT;
      end
    endcase
    if (phase_restart) begin
      sec_next = 12'h000;
    end else if (sec_tick) begin
      sec_next = sec_reg + 12'h001;
    end else begin
      sec_next = sec_reg;
    end
    // R07: downstream alone in vent pulse
    down_next = (state_next == ST_LP_PULSE);
    // R10: upstream alone in fill pulse
    up_next = (state_next == ST_HP_PULSE);
    // R15: both valves drop on lockout
    lock_next = (state_next == ST_LOCKOUT);
    busy_next = (state_next != ST_IDLE) && (state_next != ST_LOCKOUT);
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_IDLE;
      sec_reg <= 12'h000;
      test_secs_reg <= 12'h000;
      hp_follow_reg <= 1'b0;
      up_reg <= 1'b0;
      down_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      lock_reg <= 1'b0;
      pass_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sec_reg <= sec_next;
      test_secs_reg <= test_secs_next;
      hp_follow_reg <= hp_follow_next;
      up_reg <= up_next;
      down_reg <= down_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      lock_reg <= lock_next;
      pass_reg <= pass_next;
    end
  end

  // register slave
  always_comb begin
    cfg_next = cfg_reg;
    aw_hold_next = aw_hold_reg;
    awaddr_next = awaddr_reg;
    w_hold_next = w_hold_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    clear_cmd = 1'b0;
    if (s_axi_awvalid_i && awready_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_reg) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata_i;
      wstrb_next = s_axi_wstrb_i;
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case ({awaddr_reg[ADDR_W-1:2], 2'b00})
        CFG_OFF: begin
          // R13: settings open in standby or lockout
          if (control_standby_i || lock_reg) begin
            if (wstrb_reg[0]) begin
              if (wdata_reg[CFG_SCHED_LSB +: 3] <= SCHED_SPLIT) begin
                cfg_next.sched = vlvp_sched_e'(wdata_reg[CFG_SCHED_LSB +: 3]);
              end else begin
                cfg_next.sched = SCHED_NEVER;
              end
            end
            if (wstrb_reg[1]) begin
              // R12: code clamped to legal steps
              // R14: ten second floor
              if (wdata_reg[CFG_CODE_LSB +: 8] < TIME_CODE_MIN) begin
                cfg_next.time_code = TIME_CODE_MIN;
              end else if (wdata_reg[CFG_CODE_LSB +: 8] > TIME_CODE_MAX) begin
                cfg_next.time_code = TIME_CODE_MAX;
              end else begin
                cfg_next.time_code = wdata_reg[CFG_CODE_LSB +: 8];
              end
            end
          end else begin
            bresp_next = RESP_SLVERR;
          end
        end
        CMD_OFF: begin
          // R15: explicit clear of lockout
          clear_cmd = wstrb_reg[0] && wdata_reg[CMD_CLEAR_BIT];
        end
        STATUS_OFF, TIME_OFF: begin
          bresp_next = RESP_SLVERR;
        end
        default: begin
          bresp_next = RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next = !w_hold_next && !bvalid_next;
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0000_0000;
      case ({s_axi_araddr_i[ADDR_W-1:2], 2'b00})
        CFG_OFF: begin
          rdata_next[CFG_SCHED_LSB +: 3] = cfg_reg.sched;
          rdata_next[CFG_CODE_LSB +: 8] = cfg_reg.time_code;
        end
        STATUS_OFF: begin
          rdata_next[7:0] = state_reg;
          rdata_next[STAT_LOCK_BIT] = lock_reg;
          rdata_next[STAT_BUSY_BIT] = busy_reg;
          rdata_next[STAT_SW_BIT] = switch_sync;
          rdata_next[STAT_PASS_BIT] = pass_reg;
          rdata_next[STAT_SEC_LSB +: 12] = sec_reg;
        end
        TIME_OFF: begin
          rdata_next[11:0] = vlvp_code_to_secs(cfg_reg.time_code);
        end
        CMD_OFF: begin
          rdata_next = 32'h0000_0000;
        end
        default: begin
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_reg <= CFG_RST;
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      cfg_reg <= cfg_next;
      aw_hold_reg <= aw_hold_next;
      awaddr_reg <= awaddr_next;
      w_hold_reg <= w_hold_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign upstream_valve_drive_o = up_reg;
  assign downstream_valve_drive_o = down_reg;
  assign prove_busy_o = busy_reg;
  assign prove_done_o = done_reg;
  assign lockout_o = lock_reg;
  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

endmodule

/* File: tb/vlvp_sequencer_asserts.sv */
`timescale 1ns/1ps
module vlvp_sequencer_asserts
  import vlvp_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic upstream_valve_drive_o,
  input wire logic downstream_valve_drive_o,
  input wire logic prove_busy_o,
  input wire logic prove_done_o,
  input wire logic lockout_o,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o
);
  logic [31:0] dn_cnt_reg;
  logic [31:0] dn_cnt_next;
  logic [31:0] up_cnt_reg;
  logic [31:0] up_cnt_next;
  // cycles each valve has been open
  always_comb begin
    dn_cnt_next = downstream_valve_drive_o ? dn_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    up_cnt_next = upstream_valve_drive_o ? up_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dn_cnt_reg <= 32'h0000_0000;
      up_cnt_reg <= 32'h0000_0000;
    end else begin
      dn_cnt_reg <= dn_cnt_next;
      up_cnt_reg <= up_cnt_next;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_dn_close;
    $fell(downstream_valve_drive_o) && !lockout_o;
  endsequence
  sequence s_up_close;
    $fell(upstream_valve_drive_o) && !lockout_o;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  property p_dn_pulse;
    s_dn_close |-> dn_cnt_reg == PULSE_SECS * SEC_CYCLES_P;
  endproperty
  property p_up_pulse;
    s_up_close |-> up_cnt_reg == PULSE_SECS * SEC_CYCLES_P;
  endproperty
  property p_excl;
    !(upstream_valve_drive_o && downstream_valve_drive_o);
  endproperty
  property p_lock_safe;
    lockout_o |-> !upstream_valve_drive_o && !downstream_valve_drive_o && !prove_busy_o;
  endproperty
  property p_lock_hold;
    $fell(lockout_o) |-> $rose(s_axi_bvalid_o);
  endproperty
  property p_done_ok;
    prove_done_o |-> !lockout_o ##1 !prove_done_o;
  endproperty
  property p_busy_end;
    $fell(prove_busy_o) |-> prove_done_o || lockout_o;
  endproperty
  property p_valve_busy;
    (upstream_valve_drive_o || downstream_valve_drive_o) |-> prove_busy_o;
  endproperty
  property p_wr_resp;
    s_wr_take |-> ##2 s_axi_bvalid_o;
  endproperty
  property p_rd_resp;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_dn_pulse: assert property (p_dn_pulse) else $error("downstream pulse length wrong");
  a_up_pulse: assert property (p_up_pulse) else $error("upstream pulse length wrong");
  a_excl: assert property (p_excl) else $error("both valves open");
  a_lock_safe: assert property (p_lock_safe) else $error("valves or busy in lockout");
  a_lock_hold: assert property (p_lock_hold) else $error("lockout left without clear");
  a_done_ok: assert property (p_done_ok) else $error("done pulse wrong");
  a_busy_end: assert property (p_busy_end) else $error("busy ended without outcome");
  a_valve_busy: assert property (p_valve_busy) else $error("valve open outside proving");
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
endmodule

/* File: tb/vlvp_gas_model.sv */
`timescale 1ns/1ps
module vlvp_gas_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic up_open_i,
  input wire logic dn_open_i,
  input wire logic leak_up_i,
  input wire logic leak_dn_i,
  output logic switch_o
);
  logic pres_reg;
  logic pres_next;
  // space fills from upstream, drains downstream, leaks when closed
  always_comb begin
    pres_next = pres_reg;
    if (up_open_i | leak_up_i & ~dn_open_i) begin
      pres_next = 1'b1;
    end else if (dn_open_i | leak_dn_i) begin
      pres_next = 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pres_reg <= 1'b0;
    end else begin
      pres_reg <= pres_next;
    end
  end
  assign switch_o = pres_reg;
endmodule

/* File: tb/vlvp_sequencer_test.sv */
`timescale 1ns/1ps
module vlvp_sequencer_test;
  import vlvp_pkg::*;
  localparam int N = 4;
  logic core_clk_i, reset_n_i, before_req_i, after_req_i, control_standby_i, interspace_pressure_switch_i;
  logic upstream_valve_drive_o, downstream_valve_drive_o, prove_busy_o, prove_done_o, lockout_o;
  logic [3:0] s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, leak_up, leak_dn;
  int fails, checks;
  vlvp_sequencer #(.SEC_CYCLES_P(N)) DUT (.*);
  vlvp_gas_model u_gas (.core_clk_i, .reset_n_i, .up_open_i(upstream_valve_drive_o),
    .dn_open_i(downstream_valve_drive_o), .leak_up_i(leak_up), .leak_dn_i(leak_dn),
    .switch_o(interspace_pressure_switch_i));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic end_sim;
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    logic aw, w, got;
    n = 0; aw = 1'b0; w = 1'b0; got = 1'b0;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a; s_axi_wdata_i <= d; s_axi_wstrb_i <= 4'hf;
    s_axi_awvalid_i <= 1'b1; s_axi_wvalid_i <= 1'b1; s_axi_bready_i <= 1'b1;
    while (!got) begin
      @(negedge core_clk_i);
      aw = s_axi_awready_o === 1'b1; w = s_axi_wready_o === 1'b1;
      got = s_axi_bvalid_o === 1'b1; rs = s_axi_bresp_o;
      @(posedge core_clk_i);
      if (aw) s_axi_awvalid_i <= 1'b0;
      if (w) s_axi_wvalid_i <= 1'b0;
      n++;
      if (n > 40) begin
        fails++;
        end_sim;
      end
    end
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    int n;
    logic ar, got;
    n = 0; got = 1'b0;
    @(posedge core_clk_i);
    s_axi_araddr_i <= a; s_axi_arvalid_i <= 1'b1; s_axi_rready_i <= 1'b1;
    while (!got) begin
      @(negedge core_clk_i);
      ar = s_axi_arready_o === 1'b1;
      got = s_axi_rvalid_o === 1'b1; rd = s_axi_rdata_o; rs = s_axi_rresp_o;
      @(posedge core_clk_i);
      if (ar) s_axi_arvalid_i <= 1'b0;
      n++;
      if (n > 40) begin
        fails++;
        end_sim;
      end
    end
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic prove(input logic aft, input int dn, input int up, input int fin, input int tol, input logic lck);
    int c_dn, c_up, i, t_end;
    c_dn = 0; c_up = 0; t_end = -1;
    @(posedge core_clk_i);
    if (aft) after_req_i <= 1'b1;
    else before_req_i <= 1'b1;
    @(posedge core_clk_i);
    before_req_i <= 1'b0; after_req_i <= 1'b0;
    for (i = 0; i < 400 && t_end < 0; i++) begin
      #1;
      if (downstream_valve_drive_o === 1'b1) c_dn++;
      if (upstream_valve_drive_o === 1'b1) c_up++;
      if ((lck ? lockout_o : prove_done_o) === 1'b1) t_end = i;
      @(posedge core_clk_i);
    end
    chk("downstream cycles", c_dn, dn);
    chk("upstream cycles", c_up, up);
    chk("end time", t_end >= fin && t_end <= fin + tol, 1);
    if (t_end < 0) end_sim;
  endtask
  task automatic t_reset;
    rdr(CFG_OFF);
    chk("cfg reset", rd, 32'h0000_0a00);
    chk("cfg read resp", rs, RESP_OKAY);
    rdr(TIME_OFF);
    chk("time reset", rd & 32'h0000_0fff, 32'h0000_000a);
    wr(TIME_OFF, 32'h0000_0000);
    chk("time write resp", rs, RESP_SLVERR);
    rdr(STATUS_OFF);
    chk("status idle", rd & 32'h0000_03ff, 32'h0000_0001);
    prove(1'b0, 0, 0, 0, 1, 1'b0);
    prove(1'b1, 0, 0, 0, 1, 1'b0);
  endtask
  task automatic t_codes;
    logic [7:0] cd[7] = '{8'h3c, 8'h3d, 8'h72, 8'h73, 8'ha4, 8'h05, 8'hff};
    int secs[7] = '{60, 70, 600, 660, 3600, 10, 3600};
    for (int k = 0; k < 7; k++) begin
      wr(CFG_OFF, {16'h0000, cd[k], 8'h00});
      rdr(TIME_OFF);
      chk("test seconds", rd & 32'h0000_0fff, secs[k]);
    end
    wr(CFG_OFF, 32'h0000_0a00);
  endtask
  task automatic t_guard;
    @(posedge core_clk_i);
    control_standby_i <= 1'b0;
    wr(CFG_OFF, 32'h0000_1403);
    chk("cfg write outside standby", rs, RESP_SLVERR);
    rdr(CFG_OFF);
    chk("cfg kept", rd, 32'h0000_0a00);
    @(posedge core_clk_i);
    control_standby_i <= 1'b1;
  endtask
  task automatic t_sched;
    int k[8] = '{1, 0, 0, 1, 1, 1, 2, 3};
    int j;
    for (int s = 1; s < 5; s++) begin
      wr(CFG_OFF, {24'h0000_0a, 8'(s)});
      chk("cfg write resp", rs, RESP_OKAY);
      for (int p = 0; p < 2; p++) begin
        j = 2 * (s - 1) + p;
        prove(p[0], (k[j] == 1 || k[j] == 3) ? 4 * N : 0, (k[j] == 1 || k[j] == 2) ? 4 * N : 0,
          k[j] == 0 ? 0 : (k[j] == 1 ? 34 * N : 17 * N), k[j] == 0 ? 1 : 0, 1'b0);
      end
    end
  endtask
  task automatic t_leak(input logic up_side);
    wr(CFG_OFF, 32'h0000_0a03);
    leak_up <= up_side; leak_dn <= ~up_side;
    prove(1'b0, 4 * N, up_side ? 0 : 4 * N, up_side ? 7 * N : 24 * N, 3, 1'b1);
    @(posedge core_clk_i);
    leak_up <= 1'b0; leak_dn <= 1'b0;
    control_standby_i <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    #1;
    chk("lockout held", lockout_o, 1'b1);
    wr(CFG_OFF, 32'h0000_0a03);
    chk("cfg write in lockout", rs, RESP_OKAY);
    wr(CMD_OFF, 32'h0000_0001);
    #1;
    chk("lockout cleared", lockout_o, 1'b0);
    @(posedge core_clk_i);
    control_standby_i <= 1'b1;
  endtask
  initial begin
    fails = 0; checks = 0;
    reset_n_i = 1'b0; before_req_i = 1'b0; after_req_i = 1'b0; control_standby_i = 1'b1;
    leak_up = 1'b0; leak_dn = 1'b0;
    s_axi_awaddr_i = 4'h0; s_axi_araddr_i = 4'h0; s_axi_wstrb_i = 4'h0; s_axi_wdata_i = 32'h0000_0000;
    s_axi_awvalid_i = 1'b0; s_axi_wvalid_i = 1'b0; s_axi_bready_i = 1'b0;
    s_axi_arvalid_i = 1'b0; s_axi_rready_i = 1'b0;
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset;
    t_codes;
    t_guard;
    t_sched;
    t_leak(1'b1);
    t_leak(1'b0);
    end_sim;
  end
endmodule
bind vlvp_sequencer vlvp_sequencer_asserts #(.SEC_CYCLES_P(SEC_CYCLES_P)) u_chk (.core_clk_i, .reset_n_i,
  .upstream_valve_drive_o, .downstream_valve_drive_o, .prove_busy_o, .prove_done_o, .lockout_o,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o);
